/* iqp_regs.sv */
// invalidation queue pointer registers behind an AHB-Lite slave
`timescale 1ns/1ps
module iqp_regs
	import iqp_pkg::*;
#(
	parameter int HOST_ADDRESS_WIDTH = 48
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// capabilities and global status
	input  wire logic        queuedInvalidationSupport,
	input  wire logic        scalableTranslationSupport,
	input  wire logic        abortDmaModeSupport,
	input  wire logic        queuedInvalEnableStatus,
	// descriptor fetch
	input  wire logic        fetchReady,
	output logic             fetchValid,
	output logic [63:0]      fetchAddr,
	// queue state
	output logic             invalQueueError,
	output logic [15:0]      queueEntries
);
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [63:0] HAW_MASK = (HOST_ADDRESS_WIDTH >= 64) ? 64'hffff_ffff_ffff_ffff
		: ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1);

	iqp_bus_e    bus_r;
	iqp_bus_e    bus_nxt;
	logic [11:0] addr_r;
	logic [31:0] rdata_r;
	iqp_ptr_t    tail_r;
	logic [51:0] base_r;
	logic        wide_r;
	logic [2:0]  qs_r;
	logic        errTail_r;
	logic        errWidth_r;

	logic        take;
	logic        takeRead;
	logic        takeWrite;
	logic        doWrite;
	logic        qiOn;
	iqp_ptr_t    headOffset;
	logic [63:0] baseAddr;
	logic [51:0] baseWrLo;
	logic [51:0] baseWrHi;
	logic [31:0] readWord;
	logic        hitTailLo;
	logic        hitBaseLo;
	logic        hitBaseHi;
	logic        errTail_nxt;
	logic        errWidth_nxt;

	// read-back word for one register offset
	function automatic logic [31:0] regWord(
		input logic [11:0] off,
		input iqp_ptr_t    head,
		input iqp_ptr_t    tail,
		input logic [51:0] base,
		input logic        wide,
		input logic [2:0]  qs,
		input logic        err,
		input logic        busy
	);
		logic [31:0] w;
		w = 32'h0;
		case (off)
			`IQP_OFF_HEAD_LO: w[`IQP_PTR_MSB:`IQP_PTR_LSB] = head;
			`IQP_OFF_TAIL_LO: w[`IQP_PTR_MSB:`IQP_PTR_LSB] = tail;
			`IQP_OFF_BASE_LO: begin
				w[31:`IQP_BASE_LSB]              = base[19:0];
				w[`IQP_DW_BIT]                   = wide;
				w[`IQP_QS_MSB:`IQP_QS_LSB]       = qs;
			end
			`IQP_OFF_BASE_HI: w = base[51:20];
			`IQP_OFF_STATUS: begin
				w[`IQP_STAT_ERR_BIT]  = err;
				w[`IQP_STAT_BUSY_BIT] = busy;
			end
			default: w = 32'h0;
		endcase
		regWord = w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake
	assign take      = hsel & htrans[1] & hready;
	assign takeRead  = take & ~hwrite;
	assign takeWrite = take & hwrite;
	assign hreadyout = (bus_r != IQP_RD1);
	assign hresp     = 1'h0;
	assign hrdata    = rdata_r;

	always_comb begin
		case (bus_r)
			IQP_RD1: bus_nxt = IQP_RD2;
			IQP_IDLE,
			IQP_RD2,
			IQP_WR: begin
				if (takeRead) begin
					bus_nxt = IQP_RD1;
				end else if (takeWrite) begin
					bus_nxt = IQP_WR;
				end else begin
					bus_nxt = IQP_IDLE;
				end
			end
			default: bus_nxt = IQP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_r  <= IQP_IDLE;
			addr_r <= 12'h0;
		end else begin
			bus_r <= bus_nxt;
			if (take) begin
				addr_r <= haddr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register decode
	assign qiOn      = queuedInvalidationSupport;
	assign doWrite   = (bus_r == IQP_WR) & qiOn;
	assign hitTailLo = doWrite & (addr_r == `IQP_OFF_TAIL_LO);
	assign hitBaseLo = doWrite & (addr_r == `IQP_OFF_BASE_LO);
	assign hitBaseHi = doWrite & (addr_r == `IQP_OFF_BASE_HI);

	// unimplemented address bits above the host width stay zero
	assign baseWrLo = {base_r[51:20], hwdata[31:`IQP_BASE_LSB]} & HAW_MASK[63:12];
	assign baseWrHi = {hwdata, base_r[19:0]} & HAW_MASK[63:12];
	assign baseAddr = {base_r, 12'h000};

	assign readWord = qiOn ? regWord(addr_r, headOffset, tail_r, base_r, wide_r, qs_r,
		invalQueueError, fetchValid) : 32'h0;

	////////////////////////////////////////////////////////////////////////////////
	// software-written state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tail_r <= `IQP_RST_PTR;
			base_r <= `IQP_RST_BASE;
			wide_r <= `IQP_RST_DW;
			qs_r   <= `IQP_RST_QS;
		end else begin
			if (hitTailLo) begin
				tail_r <= hwdata[`IQP_PTR_MSB:`IQP_PTR_LSB];
			end
			if (hitBaseLo) begin
				base_r <= baseWrLo;
				wide_r <= hwdata[`IQP_DW_BIT];
				qs_r   <= hwdata[`IQP_QS_MSB:`IQP_QS_LSB];
			end else if (hitBaseHi) begin
				base_r <= baseWrHi;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0;
		end else if (bus_r == IQP_RD1) begin
			rdata_r <= readWord;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// queue error detection
	assign errTail_nxt  = qiOn & wide_r & tail_r[0];
	assign errWidth_nxt = qiOn & wide_r & ~scalableTranslationSupport
		& ~abortDmaModeSupport;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			errTail_r  <= 1'h0;
			errWidth_r <= 1'h0;
		end else begin
			errTail_r  <= errTail_nxt;
			errWidth_r <= errWidth_nxt;
		end
	end

	assign invalQueueError = errTail_r | errWidth_r;
	assign queueEntries    = iqpEntries(qs_r, wide_r);

	////////////////////////////////////////////////////////////////////////////////
	// head and fetch engine
	iqp_fetch u_fetch (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.enableStatus (queuedInvalEnableStatus & qiOn),
		.queueError   (invalQueueError),
		.wideDesc     (wide_r),
		.queueSizeExp (qs_r),
		.tailOffset   (tail_r),
		.baseAddr     (baseAddr),
		.fetchReady   (fetchReady),
		.fetchValid   (fetchValid),
		.fetchAddr    (fetchAddr),
		.headOffset   (headOffset)
	);
endmodule // iqp_regs

/* iqp_defines.svh */
// register offsets, field positions and reset values of the invalidation queue pointers
// Overview of operation
// - no queued invalidation: registers read zero
// - head field bits 18:4 read-only, next descriptor
// - wide descriptors: head bit 4 forced zero
// - head cleared while queue enable status clear
// - wide descriptors: tail bit 4 set errors
// - base held in bits 63:12, 4KB aligned
// - base bits above address width unimplemented
// - base reads return last written value, bits above address width zero
// - bit 11 selects 128 or 256-bit descriptors
// - wide without scalable or abort support errors
// - size field X gives 2^X 4KB pages
// - entries 2^(X+8) narrow, 2^(X+7) wide
`ifndef IQP_DEFINES_SVH
`define IQP_DEFINES_SVH

`define IQP_OFF_HEAD_LO   12'h080
`define IQP_OFF_HEAD_HI   12'h084
`define IQP_OFF_TAIL_LO   12'h088
`define IQP_OFF_TAIL_HI   12'h08c
`define IQP_OFF_BASE_LO   12'h090
`define IQP_OFF_BASE_HI   12'h094
`define IQP_OFF_STATUS    12'h098

`define IQP_PTR_LSB       4
`define IQP_PTR_MSB       18
`define IQP_BASE_LSB      12
`define IQP_DW_BIT        11
`define IQP_QS_MSB        2
`define IQP_QS_LSB        0
`define IQP_STAT_ERR_BIT  0
`define IQP_STAT_BUSY_BIT 1

`define IQP_RST_PTR       15'h0000
`define IQP_RST_BASE      52'h0_0000_0000_0000
`define IQP_RST_QS        3'h0
`define IQP_RST_DW        1'h0

`define IQP_NARROW_EXP    4'h8
`define IQP_WIDE_EXP      4'h7

`endif

/* iqp_pkg.sv */
// types and shared functions of the invalidation queue pointers
package iqp_pkg;
	`include "iqp_defines.svh"

	typedef logic [14:0] iqp_ptr_t;

	typedef enum logic [1:0] {
		IQP_IDLE = 2'h0,
		IQP_RD1  = 2'h1,
		IQP_RD2  = 2'h3,
		IQP_WR   = 2'h2
	} iqp_bus_e;

	// entries in the queue for a size and a width
	function automatic logic [15:0] iqpEntries(input logic [2:0] qs, input logic wide);
		logic [3:0] e;
		e = (wide ? `IQP_WIDE_EXP : `IQP_NARROW_EXP) + {1'h0, qs};
		iqpEntries = 16'h1 << e;
	endfunction

	// wrap mask in 16-byte units: 2^X pages of 256 units each
	function automatic logic [15:0] iqpUnitMask(input logic [2:0] qs);
		logic [3:0] e;
		e = `IQP_NARROW_EXP + {1'h0, qs};
		iqpUnitMask = (16'h1 << e) - 16'h1;
	endfunction
endpackage

/* iqp_fetch.sv */
// head pointer and descriptor fetch engine
`timescale 1ns/1ps
module iqp_fetch
	import iqp_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// configuration
	input  wire logic        enableStatus,
	input  wire logic        queueError,
	input  wire logic        wideDesc,
	input  wire logic [2:0]  queueSizeExp,
	input  wire iqp_ptr_t    tailOffset,
	input  wire logic [63:0] baseAddr,
	// descriptor fetch
	input  wire logic        fetchReady,
	output logic             fetchValid,
	output logic [63:0]      fetchAddr,
	// state
	output iqp_ptr_t         headOffset
);
	////////////////////////////////////////////////////////////////////////////////
	iqp_ptr_t    head_r;
	iqp_ptr_t    head_nxt;
	logic [63:0] addr_r;
	logic [15:0] stepUnits;
	logic [15:0] headSum;
	logic [15:0] headWrap;
	logic        advance;
	iqp_ptr_t    tailCmp;

	assign tailCmp    = wideDesc ? {tailOffset[14:1], 1'h0} : tailOffset;
	assign fetchValid = enableStatus & ~queueError & (head_r != tailCmp);
	assign advance    = fetchValid & fetchReady;
	assign stepUnits  = wideDesc ? 16'h2 : 16'h1;
	assign headSum    = {1'h0, head_r} + stepUnits;
	assign headWrap   = headSum & iqpUnitMask(queueSizeExp);

	always_comb begin
		head_nxt = head_r;
		if (advance) begin
			head_nxt = headWrap[14:0];
		end
		if (wideDesc) begin
			head_nxt[0] = 1'h0;
		end
		if (!enableStatus) begin
			head_nxt = `IQP_RST_PTR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			head_r <= `IQP_RST_PTR;
			addr_r <= 64'h0;
		end else begin
			head_r <= head_nxt;
			addr_r <= baseAddr + {45'h0, head_nxt, 4'h0};
		end
	end

	assign fetchAddr  = addr_r;
	assign headOffset = head_r;
endmodule // iqp_fetch

/* iqp_regs_props.sv */
// assertion checker for the invalidation queue pointer registers
`timescale 1ns/1ps
module iqp_regs_props
	import iqp_pkg::*;
#(
	parameter int HOST_ADDRESS_WIDTH = 48
) (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// register bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// queue
	input wire logic        queuedInvalidationSupport,
	input wire logic        queuedInvalEnableStatus,
	input wire logic        fetchReady,
	input wire logic        fetchValid,
	input wire logic [63:0] fetchAddr,
	input wire logic        invalQueueError,
	input wire logic [15:0] queueEntries
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	chk_nosupp_reads_zero: assert property (!queuedInvalidationSupport && !hreadyout |=>
		hrdata == 32'h0) else $error("read without support not zero");
	chk_read_one_wait: assert property (hsel && htrans[1] && !hwrite && hready |=>
		!hreadyout ##1 hreadyout) else $error("read wait state wrong");
	chk_resp_okay: assert property (hresp == 1'h0) else $error("response not okay");
	chk_disabled_idle: assert property (!queuedInvalEnableStatus |-> !fetchValid)
		else $error("fetch while disabled");
	chk_error_halts: assert property (invalQueueError |-> !fetchValid)
		else $error("fetch while queue error");
	chk_entries_pow: assert property ($onehot(queueEntries) && queueEntries >= 16'h80)
		else $error("queue entries not a power of two");
	chk_addr_aligned: assert property (fetchAddr[3:0] == 4'h0)
		else $error("fetch address misaligned");
	chk_fetch_advance: assert property (fetchValid && fetchReady |=>
		fetchAddr != $past(fetchAddr) || !queuedInvalEnableStatus)
		else $error("head did not advance");
	chk_valid_holds: assert property (fetchValid && !fetchReady && !hsel && !$past(hsel) |=>
		fetchValid || !queuedInvalEnableStatus) else $error("request dropped");
	cover property (fetchValid && fetchReady);
	cover property (invalQueueError);
	cover property (hsel && htrans[1] && !hwrite ##2 hreadyout);
endmodule // iqp_regs_props

bind iqp_regs iqp_regs_props #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) iqp_regs_props_inst (
	.ref_clk                   (ref_clk),
	.rst_n                     (rst_n),
	.hsel                      (hsel),
	.htrans                    (htrans),
	.hwrite                    (hwrite),
	.hready                    (hready),
	.hreadyout                 (hreadyout),
	.hresp                     (hresp),
	.hrdata                    (hrdata),
	.queuedInvalidationSupport (queuedInvalidationSupport),
	.queuedInvalEnableStatus   (queuedInvalEnableStatus),
	.fetchReady                (fetchReady),
	.fetchValid                (fetchValid),
	.fetchAddr                 (fetchAddr),
	.invalQueueError           (invalQueueError),
	.queueEntries              (queueEntries)
);

/* tb_top.sv */
// self-checking testbench for the invalidation queue pointer registers
`timescale 1ns/1ps
module tb_top
	import iqp_pkg::*;
;
	logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        queuedInvalidationSupport, scalableTranslationSupport;
	logic        abortDmaModeSupport, queuedInvalEnableStatus;
	logic        fetchReady, fetchValid, invalQueueError;
	logic [63:0] fetchAddr;
	logic [15:0] queueEntries;
	int          failCount, nChecks;

	assign hready = hreadyout;
	iqp_regs #(.HOST_ADDRESS_WIDTH(48)) iqp_regs_inst (
		.ref_clk                    (ref_clk),
		.rst_n                      (rst_n),
		.hsel                       (hsel),
		.haddr                      (haddr),
		.htrans                     (htrans),
		.hwrite                     (hwrite),
		.hsize                      (hsize),
		.hwdata                     (hwdata),
		.hready                     (hready),
		.hreadyout                  (hreadyout),
		.hresp                      (hresp),
		.hrdata                     (hrdata),
		.queuedInvalidationSupport  (queuedInvalidationSupport),
		.scalableTranslationSupport (scalableTranslationSupport),
		.abortDmaModeSupport        (abortDmaModeSupport),
		.queuedInvalEnableStatus    (queuedInvalEnableStatus),
		.fetchReady                 (fetchReady),
		.fetchValid                 (fetchValid),
		.fetchAddr                  (fetchAddr),
		.invalQueueError            (invalQueueError),
		.queueEntries               (queueEntries)
	);

	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		nChecks++;
		if (s !== e) begin
			failCount++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	// hready is stable from the falling edge to the next rising edge
	task automatic waitRdy();
		do @(negedge ref_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
		@(posedge ref_clk);
	endtask

	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		waitRdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'h1, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(a, 1'h0, 32'h0);
		chk(rd, e);
	endtask

	// stall a few cycles, then consume until the queue is empty
	task automatic drain();
		int n;
		repeat (3) @(posedge ref_clk);
		fetchReady <= 1'h1;
		n = 0;
		do @(negedge ref_clk); while (fetchValid && ++n < 600);
		@(posedge ref_clk);
		fetchReady <= 1'h0;
	endtask

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////
	// about 400 cycles expected
	initial begin
		#100000;
		failCount++;
		tallyAndFinish();
	end

	initial begin
		rst_n = 1'h0;
		hsel = 1'h0;
		haddr = 12'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		queuedInvalidationSupport = 1'h1;
		scalableTranslationSupport = 1'h1;
		abortDmaModeSupport = 1'h0;
		queuedInvalEnableStatus = 1'h1;
		fetchReady = 1'h0;
		failCount = 0;
		nChecks = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 8; i++) rdchk(12'h80 + 12'(4 * i), 32'h0);
		wr(12'h090, 32'h0000_5000);
		wr(12'h088, 32'h0000_0030);
		@(negedge ref_clk);
		chk(fetchValid, 1'h1);
		chk(fetchAddr, 64'h5000);
		@(posedge ref_clk);
		rdchk(12'h098, 32'h2);
		drain();
		rdchk(12'h080, 32'h30);
		wr(12'h080, 32'h70);
		rdchk(12'h080, 32'h30);
		wr(12'h088, 32'h0);
		drain();
		rdchk(12'h080, 32'h0);
		chk(queueEntries, 16'h100);
		wr(12'h090, 32'h0000_5803);
		@(negedge ref_clk);
		chk(queueEntries, 16'h400);
		@(posedge ref_clk);
		wr(12'h088, 32'h10);
		repeat (2) @(negedge ref_clk);
		chk(invalQueueError, 1'h1);
		chk(fetchValid, 1'h0);
		@(posedge ref_clk);
		rdchk(12'h098, 32'h1);
		wr(12'h088, 32'h40);
		repeat (2) @(negedge ref_clk);
		chk(invalQueueError, 1'h0);
		drain();
		rdchk(12'h080, 32'h40);
		for (int i = 0; i < 4; i++) begin
			{scalableTranslationSupport, abortDmaModeSupport} <= 2'(i);
			repeat (2) @(negedge ref_clk);
			chk(invalQueueError, i == 0);
			@(posedge ref_clk);
		end
		wr(12'h094, 32'hffff_ffff);
		rdchk(12'h094, 32'h0000_ffff);
		rdchk(12'h090, 32'h0000_5803);
		queuedInvalEnableStatus <= 1'h0;
		rdchk(12'h080, 32'h0);
		chk(fetchValid, 1'h0);
		queuedInvalidationSupport <= 1'h0;
		rdchk(12'h088, 32'h0);
		wr(12'h088, 32'h70);
		queuedInvalidationSupport <= 1'h1;
		rdchk(12'h088, 32'h40);
		tallyAndFinish();
	end
endmodule // tb_top
